/* inc/coe_pkg.sv */
// Shared constants for the operand datapath and address generator
// Assumes a single core clock and an asynchronous active-low reset
package coe_pkg;
  localparam int unsigned REG_W = 32;
  localparam int unsigned SW_W = 16;
  // Operand size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Addressing mode codes
  localparam logic [3:0] M_DREG = 4'h0;
  localparam logic [3:0] M_AREG = 4'h1;
  localparam logic [3:0] M_IND = 4'h2;
  localparam logic [3:0] M_POSTINC = 4'h3;
  localparam logic [3:0] M_PREDEC = 4'h4;
  localparam logic [3:0] M_DISP = 4'h5;
  localparam logic [3:0] M_INDEX = 4'h6;
  localparam logic [3:0] M_ABS_S = 4'h7;
  localparam logic [3:0] M_ABS_L = 4'h8;
  localparam logic [3:0] M_PC_DISP = 4'h9;
  localparam logic [3:0] M_PC_INDEX = 4'hA;
  localparam logic [3:0] M_IMM = 4'hB;
  localparam logic [3:0] M_QUICK = 4'hC;
  localparam logic [3:0] M_IMPLIED = 4'hD;
  // Implied register select
  localparam logic [1:0] IMP_SW = 2'h0;
  localparam logic [1:0] IMP_USP = 2'h1;
  localparam logic [1:0] IMP_SSP = 2'h2;
  localparam logic [1:0] IMP_PC = 2'h3;
  // Status word field positions
  localparam int unsigned SW_C = 0;
  localparam int unsigned SW_V = 1;
  localparam int unsigned SW_Z = 2;
  localparam int unsigned SW_N = 3;
  localparam int unsigned SW_X = 4;
  localparam int unsigned SW_IM_LO = 8;
  localparam int unsigned SW_IM_HI = 10;
  localparam int unsigned SW_S = 13;
  localparam int unsigned SW_T = 15;
  localparam logic [15:0] SW_DEF_MASK = 16'hA71F;
  localparam logic [15:0] SW_RST = 16'h2700;
  // Address steps and layout
  localparam logic [2:0] STEP_B = 3'h1;
  localparam logic [2:0] STEP_W = 3'h2;
  localparam logic [2:0] STEP_L = 3'h4;
  localparam logic [2:0] SP_IDX = 3'h7;
  localparam logic [31:0] LONG_LO_OFS = 32'h0000_0002;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

/* verilog/coe_ea_gen.sv */
// Effective address adder for memory addressing modes
// Assumes the base is already predecremented by the caller
`timescale 1ns/1ps
module coe_ea_gen (
  input wire logic [3:0] i_mode,
  input wire logic [31:0] i_base,
  input wire logic [31:0] i_index,
  input wire logic [15:0] i_ext0,
  input wire logic [15:0] i_ext1,
  input wire logic [31:0] i_pc,
  output logic [31:0] o_ea,
  output logic o_is_mem
);
  logic [31:0] long_displacement;
  logic [31:0] short_displacement;
  logic [31:0] indexed;

  assign long_displacement = {{16{i_ext0[15]}}, i_ext0};
  assign short_displacement = {{24{i_ext0[7]}}, i_ext0[7:0]};
  assign indexed = i_index + short_displacement;

  always_comb begin
    o_is_mem = 1'b1;
    case (i_mode)
      coe_pkg::M_IND, coe_pkg::M_POSTINC, coe_pkg::M_PREDEC: o_ea = i_base;
      coe_pkg::M_DISP: o_ea = i_base + long_displacement;
      coe_pkg::M_INDEX: o_ea = i_base + indexed;
      coe_pkg::M_PC_DISP: o_ea = i_pc + long_displacement;
      coe_pkg::M_PC_INDEX: o_ea = i_pc + indexed;
      coe_pkg::M_ABS_S: o_ea = long_displacement;
      coe_pkg::M_ABS_L: o_ea = {i_ext0, i_ext1};
      default: begin
        o_ea = coe_pkg::ZERO32;
        o_is_mem = 1'b0;
      end
    endcase
  end
endmodule

/* verilog/coe_operand_ea.sv */
// Operand datapath: register file, status word, address generation, fetch
// Assumes decoder holds request inputs steady in the accept cycle
`timescale 1ns/1ps

module coe_operand_ea (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_op_valid,
  input wire logic [3:0] i_ea_mode,
  input wire logic [1:0] i_op_size,
  input wire logic [2:0] i_addr_reg_sel,
  input wire logic [3:0] i_index_reg_sel,
  input wire logic i_index_long,
  input wire logic [15:0] i_ext_word0,
  input wire logic [15:0] i_ext_word1,
  input wire logic [7:0] i_quick_data,
  input wire logic [1:0] i_implied_sel,
  input wire logic [31:0] i_pc,
  input wire logic i_wr_en,
  input wire logic i_wr_is_addr,
  input wire logic [2:0] i_wr_sel,
  input wire logic [1:0] i_wr_size,
  input wire logic [31:0] i_wr_data,
  input wire logic i_sw_wr_en,
  input wire logic i_sw_wr_byte,
  input wire logic [15:0] i_sw_wr_data,
  input wire logic [3:0] i_rd_sel,
  input wire logic [1:0] i_rd_size,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  output logic o_busy,
  output logic o_op_done,
  output logic [31:0] o_op_data,
  output logic [31:0] o_ea,
  output logic o_align_err,
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  output logic o_wr_refused,
  output logic [31:0] o_rd_data,
  output logic [15:0] o_status_word
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FETCH = 2'b10
  } coe_state_type;

  coe_state_type state_q;
  logic [31:0] d_q [8];
  logic [31:0] a_q [7];
  logic [31:0] usp_q;
  logic [31:0] ssp_q;
  logic [15:0] sw_q;
  logic [31:0] a_view [8];
  logic [1:0] size_q;
  logic second_q;
  logic [31:0] data_q;

  // Size mask for operand portion
  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    size_mask = (sz == coe_pkg::SZ_BYTE) ? 32'h0000_00FF :
                (sz == coe_pkg::SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  endfunction

  // Address step by size and register
  function automatic logic [31:0] step_of(input logic [1:0] sz, input logic sp);
    logic [2:0] s;
    s = (sz == coe_pkg::SZ_LONG) ? coe_pkg::STEP_L : coe_pkg::STEP_W;
    if (sz == coe_pkg::SZ_BYTE && !sp) begin
      s = coe_pkg::STEP_B;
    end
    step_of = {29'h0, s};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  logic sup;
  assign sup = sw_q[coe_pkg::SW_S];
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      a_view[i] = a_q[i];
    end
    a_view[7] = sup ? ssp_q : usp_q;
  end

  // Request decode
  logic accept;
  logic is_sp;
  logic [31:0] base;
  logic [31:0] step;
  logic [31:0] base_eff;
  logic [31:0] idx_raw;
  logic [31:0] idx_val;
  logic [31:0] ea;
  logic is_mem;
  logic misalign;
  logic [31:0] imm_val;
  logic [31:0] imp_val;
  logic [31:0] direct_val;
  assign accept = i_op_valid && state_q == ST_IDLE;
  assign is_sp = i_addr_reg_sel == coe_pkg::SP_IDX;
  assign base = a_view[i_addr_reg_sel];
  assign step = step_of(i_op_size, is_sp);
  assign base_eff = (i_ea_mode == coe_pkg::M_PREDEC) ? base - step : base;
  assign idx_raw = i_index_reg_sel[3] ? a_view[i_index_reg_sel[2:0]] :
                   d_q[i_index_reg_sel[2:0]];
  assign idx_val = i_index_long ? idx_raw : sext16(idx_raw[15:0]);
  assign misalign = is_mem && i_op_size != coe_pkg::SZ_BYTE && ea[0];
  assign imm_val = (i_op_size == coe_pkg::SZ_LONG) ? {i_ext_word0, i_ext_word1} :
                   {16'h0, i_ext_word0} & size_mask(i_op_size);
  assign imp_val = (i_implied_sel == coe_pkg::IMP_SW) ? {16'h0, sw_q} :
                   (i_implied_sel == coe_pkg::IMP_USP) ? usp_q :
                   (i_implied_sel == coe_pkg::IMP_SSP) ? ssp_q : i_pc;
  assign direct_val =
    (i_ea_mode == coe_pkg::M_DREG) ? d_q[i_addr_reg_sel] & size_mask(i_op_size) :
    (i_ea_mode == coe_pkg::M_AREG) ? base & size_mask(i_op_size) :
    (i_ea_mode == coe_pkg::M_IMM) ? imm_val :
    (i_ea_mode == coe_pkg::M_QUICK) ? {{24{i_quick_data[7]}}, i_quick_data} :
    (i_ea_mode == coe_pkg::M_IMPLIED) ? imp_val : coe_pkg::ZERO32;

  coe_ea_gen u_ea_gen (
    .i_mode(i_ea_mode),
    .i_base(base_eff),
    .i_index(idx_val),
    .i_ext0(i_ext_word0),
    .i_ext1(i_ext_word1),
    .i_pc(i_pc),
    .o_ea(ea),
    .o_is_mem(is_mem)
  );

  // Address register update sources
  logic wr_a;
  logic wr_d;
  logic ea_upd;
  logic [31:0] a_wr_val;
  logic [31:0] ea_upd_val;
  assign wr_a = i_wr_en && i_wr_is_addr && i_wr_size != coe_pkg::SZ_BYTE;
  assign wr_d = i_wr_en && !i_wr_is_addr;
  assign a_wr_val = (i_wr_size == coe_pkg::SZ_WORD) ? sext16(i_wr_data[15:0]) : i_wr_data;
  assign ea_upd = accept && !misalign &&
                  (i_ea_mode == coe_pkg::M_POSTINC || i_ea_mode == coe_pkg::M_PREDEC) &&
                  !(wr_a && i_wr_sel == i_addr_reg_sel);
  assign ea_upd_val = (i_ea_mode == coe_pkg::M_PREDEC) ? base_eff : base + step;

  logic [31:0] d_merge;
  assign d_merge = (d_q[i_wr_sel] & ~size_mask(i_wr_size)) |
                   (i_wr_data & size_mask(i_wr_size));

  // Status word next value
  logic [15:0] sw_d;
  assign sw_d = (i_sw_wr_byte || !sup) ? {sw_q[15:8], i_sw_wr_data[7:0]} : i_sw_wr_data;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 8; i++) begin
        d_q[i] <= coe_pkg::ZERO32;
      end
    end else if (wr_d) begin
      d_q[i_wr_sel] <= d_merge;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 7; i++) begin
        a_q[i] <= coe_pkg::ZERO32;
      end
      usp_q <= coe_pkg::ZERO32;
      ssp_q <= coe_pkg::ZERO32;
    end else begin
      if (ea_upd && !is_sp) begin
        a_q[i_addr_reg_sel] <= ea_upd_val;
      end else if (ea_upd) begin
        if (sup) ssp_q <= ea_upd_val;
        else usp_q <= ea_upd_val;
      end
      if (wr_a && i_wr_sel != coe_pkg::SP_IDX) begin
        a_q[i_wr_sel] <= a_wr_val;
      end else if (wr_a) begin
        if (sup) ssp_q <= a_wr_val;
        else usp_q <= a_wr_val;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sw_q <= coe_pkg::SW_RST;
    end else if (i_sw_wr_en) begin
      sw_q <= sw_d & coe_pkg::SW_DEF_MASK;
    end
  end
  assign o_status_word = sw_q;

  // Read port
  logic [31:0] rd_val;
  logic [1:0] rd_sz;
  assign rd_sz = (i_rd_sel[3] && i_rd_size == coe_pkg::SZ_BYTE) ? coe_pkg::SZ_WORD : i_rd_size;
  assign rd_val = (i_rd_sel[3] ? a_view[i_rd_sel[2:0]] : d_q[i_rd_sel[2:0]]) &
                  size_mask(rd_sz);
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= coe_pkg::ZERO32;
      o_wr_refused <= 1'b0;
    end else begin
      o_rd_data <= rd_val;
      o_wr_refused <= i_wr_en && i_wr_is_addr && !wr_a;
    end
  end

  // Fetch data assembly
  logic [31:0] fetch_val;
  logic last_beat;
  assign fetch_val = (size_q == coe_pkg::SZ_BYTE) ?
                     {24'h0, o_mem_addr[0] ? i_mem_rdata[7:0] : i_mem_rdata[15:8]} :
                     (size_q == coe_pkg::SZ_WORD) ? {16'h0, i_mem_rdata} :
                     {data_q[31:16], i_mem_rdata};
  assign last_beat = size_q != coe_pkg::SZ_LONG || second_q;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      o_busy <= 1'b0;
      o_op_done <= 1'b0;
      o_op_data <= coe_pkg::ZERO32;
      o_ea <= coe_pkg::ZERO32;
      o_align_err <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_addr <= coe_pkg::ZERO32;
      size_q <= coe_pkg::SZ_BYTE;
      second_q <= 1'b0;
      data_q <= coe_pkg::ZERO32;
    end else begin
      o_op_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            o_ea <= ea;
            size_q <= i_op_size;
            second_q <= 1'b0;
            o_align_err <= misalign;
            if (is_mem && !misalign) begin
              state_q <= ST_FETCH;
              o_busy <= 1'b1;
              o_mem_req <= 1'b1;
              o_mem_addr <= ea;
            end else begin
              o_op_done <= 1'b1;
              o_op_data <= direct_val;
            end
          end
        end
        ST_FETCH: begin
          if (i_mem_ack && !last_beat) begin
            data_q <= {i_mem_rdata, 16'h0};
            second_q <= 1'b1;
            o_mem_addr <= o_mem_addr + coe_pkg::LONG_LO_OFS;
          end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_busy <= 1'b0;
            o_op_done <= 1'b1;
            o_op_data <= fetch_val;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          o_busy <= 1'b0;
          o_mem_req <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  AST_POST_EA: assert property (
    accept && i_ea_mode == coe_pkg::M_POSTINC |=> o_ea == $past(base))
    else $error("Postincrement address not the old register");
  AST_PRE_STEP: assert property (
    accept && i_ea_mode == coe_pkg::M_PREDEC |=>
    $past(base) - o_ea == (($past(i_op_size) == coe_pkg::SZ_LONG) ? 32'h4 :
    ($past(i_op_size) == coe_pkg::SZ_WORD || $past(is_sp)) ? 32'h2 : 32'h1))
    else $error("Predecrement step wrong");
  AST_SP_BYTE: assert property (
    accept && is_sp && i_op_size == coe_pkg::SZ_BYTE &&
    i_ea_mode == coe_pkg::M_PREDEC |=> !o_ea[0] || o_align_err)
    else $error("Stack pointer lost word alignment");
  AST_DISP: assert property (
    accept && i_ea_mode == coe_pkg::M_DISP |=>
    o_ea == $past(base) + sext16($past(i_ext_word0)))
    else $error("Displacement address wrong");
  AST_ABS_S: assert property (
    accept && i_ea_mode == coe_pkg::M_ABS_S |=> o_ea == sext16($past(i_ext_word0)))
    else $error("Absolute short address wrong");
  AST_ALIGN: assert property (
    o_mem_req && size_q != coe_pkg::SZ_BYTE |-> !o_mem_addr[0])
    else $error("Word access at odd address");
  AST_LONG_LO: assert property (
    o_mem_req && i_mem_ack && !last_beat |=> o_mem_req && o_mem_addr == $past(o_mem_addr) + 2)
    else $error("Long low word not at n+2");
  AST_SW_RSV: assert property (
    (o_status_word & ~coe_pkg::SW_DEF_MASK) == 16'h0000)
    else $error("Reserved status bit set");
  AST_USER_UPPER: assert property (
    !sup && i_sw_wr_en |=> $stable(o_status_word[15:8]))
    else $error("User state changed upper status byte");
  AST_DREG_KEEP: assert property (
    wr_d && i_wr_size == coe_pkg::SZ_BYTE |=>
    d_q[$past(i_wr_sel)][31:8] == $past(d_q[i_wr_sel][31:8]))
    else $error("Byte write altered upper bits");
  AST_DIRECT_DONE: assert property (
    accept && !is_mem |=> o_op_done && !o_busy)
    else $error("Direct operand not delivered");

  COV_LONG: cover property (o_mem_req && i_mem_ack && !last_beat ##[1:8] o_op_done);
  COV_POST: cover property (accept && i_ea_mode == coe_pkg::M_POSTINC);
  COV_MIS: cover property (o_align_err && o_op_done);
  COV_SW: cover property (i_sw_wr_en && sup);
endmodule

/* dv/coe_mem_model.sv */
// Operand memory partner: answers word reads with a random wait
// Assumes the request and address are held until acknowledged
`timescale 1ns/1ps
module coe_mem_model #(
  parameter logic [31:0] SEED = 32'h1357_9BDF
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_mem_req,
  input wire logic [31:0] i_mem_addr,
  output logic o_mem_ack,
  output logic [15:0] o_mem_rdata
);
  logic [31:0] rnd_q;
  logic [1:0] wait_q;
  logic busy_q;
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rnd_q <= SEED;
      wait_q <= 2'h0;
      busy_q <= 1'b0;
      o_mem_ack <= 1'b0;
      o_mem_rdata <= 16'hFFFF;
    end else begin
      rnd_q <= {rnd_q[30:0], rnd_q[31] ^ rnd_q[21] ^ rnd_q[1] ^ rnd_q[0]};
      o_mem_rdata <= ~o_mem_rdata;
      o_mem_ack <= 1'b0;
      if (o_mem_ack) begin
        busy_q <= 1'b0;
      end else if (i_mem_req && !busy_q) begin
        busy_q <= 1'b1;
        wait_q <= rnd_q[1:0];
      end else if (busy_q && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        o_mem_ack <= 1'b1;
        o_mem_rdata <= {mem_byte({i_mem_addr[31:1], 1'b0}), mem_byte({i_mem_addr[31:1], 1'b1})};
      end
    end
  end
endmodule

/* dv/coe_operand_ea_bench.sv */
// Self-checking bench for the operand datapath and address generator
// Assumes the memory partner model serves every operand fetch
`timescale 1ns/1ps
module coe_operand_ea_bench;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] ea;
    logic [31:0] m;
    logic err;
  } coe_note_type;
  logic i_ref_clk, i_arst_n, i_op_valid, i_index_long, i_wr_en, i_wr_is_addr;
  logic i_sw_wr_en, i_sw_wr_byte, i_mem_ack;
  logic [3:0] i_ea_mode, i_index_reg_sel, i_rd_sel;
  logic [1:0] i_op_size, i_implied_sel, i_wr_size, i_rd_size;
  logic [2:0] i_addr_reg_sel, i_wr_sel;
  logic [15:0] i_ext_word0, i_ext_word1, i_sw_wr_data, i_mem_rdata, o_status_word;
  logic [7:0] i_quick_data;
  logic [31:0] i_pc, i_wr_data, o_op_data, o_ea, o_mem_addr, o_rd_data;
  logic o_busy, o_op_done, o_align_err, o_mem_req, o_wr_refused;
  int err_count, n_compared, n_ref, r0;
  logic [31:0] seed, t, ea, d, xv, base, step, supervisor_stack_ptr, dreg[8], areg[8];
  logic [15:0] e0;
  logic [3:0] md, mm[9];
  logic [2:0] b;
  logic [1:0] sz;
  coe_note_type notes[$];
  coe_note_type nt;

  coe_operand_ea u_coe_operand_ea (.i_ref_clk, .i_arst_n, .i_op_valid, .i_ea_mode,
    .i_op_size, .i_addr_reg_sel, .i_index_reg_sel, .i_index_long, .i_ext_word0,
    .i_ext_word1, .i_quick_data, .i_implied_sel, .i_pc, .i_wr_en, .i_wr_is_addr,
    .i_wr_sel, .i_wr_size, .i_wr_data, .i_sw_wr_en, .i_sw_wr_byte, .i_sw_wr_data,
    .i_rd_sel, .i_rd_size, .i_mem_ack, .i_mem_rdata, .o_busy, .o_op_done, .o_op_data,
    .o_ea, .o_align_err, .o_mem_req, .o_mem_addr, .o_wr_refused, .o_rd_data,
    .o_status_word);
  coe_mem_model u_coe_mem_model (.i_ref_clk, .i_arst_n, .i_mem_req(o_mem_req),
    .i_mem_addr(o_mem_addr), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
  function automatic logic [31:0] szm(input logic [1:0] s);
    return s == coe_pkg::SZ_BYTE ? 32'h0000_00FF : s == coe_pkg::SZ_WORD ? 32'h0000_FFFF
      : 32'hFFFF_FFFF;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic ad, input logic [2:0] sel, input logic [1:0] s,
                    input logic [31:0] v);
    @(posedge i_ref_clk);
    i_wr_en <= 1'b1;
    i_wr_is_addr <= ad;
    i_wr_sel <= sel;
    i_wr_size <= s;
    i_wr_data <= v;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
    if (!ad) dreg[sel] = (dreg[sel] & ~szm(s)) | (v & szm(s));
    else if (s != coe_pkg::SZ_BYTE) areg[sel] = s == coe_pkg::SZ_WORD ? sx16(v[15:0]) : v;
  endtask
  task automatic rd(input logic [3:0] sel, input logic [1:0] s, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd_sel <= sel;
    i_rd_size <= s;
    repeat (2) @(posedge i_ref_clk);
    #1 check("rd_data", o_rd_data, exp);
  endtask
  task automatic sw(input logic by, input logic [15:0] v, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_sw_wr_en <= 1'b1;
    i_sw_wr_byte <= by;
    i_sw_wr_data <= v;
    @(posedge i_ref_clk);
    i_sw_wr_en <= 1'b0;
    #1 check("status_word", {16'h0, o_status_word}, {16'h0, exp});
  endtask
  task automatic op(input logic [3:0] m, input logic [1:0] s, input logic [2:0] br,
                    input logic [3:0] x, input logic xl, input logic [15:0] w0, w1,
                    input logic [31:0] dv, ev, input logic er);
    int k;
    notes.push_back('{dv, ev, szm(s), er});
    @(posedge i_ref_clk);
    i_op_valid <= 1'b1;
    i_ea_mode <= m;
    i_op_size <= s;
    i_addr_reg_sel <= br;
    i_index_reg_sel <= x;
    i_index_long <= xl;
    i_ext_word0 <= w0;
    i_ext_word1 <= w1;
    @(posedge i_ref_clk);
    i_op_valid <= 1'b0;
    k = 0;
    while (notes.size() != 0 && k < 60) begin
      @(posedge i_ref_clk);
      k++;
    end
  endtask

  always @(posedge i_ref_clk) begin
    if (o_wr_refused === 1'b1) n_ref++;
    if (o_op_done === 1'b1 && notes.size() != 0) begin
      nt = notes.pop_front();
      check("op_ea", o_ea, nt.ea);
      check("op_err", {31'h0, o_align_err}, {31'h0, nt.err});
      check("op_busy", {31'h0, o_busy}, 32'h0);
      check("op_req", {31'h0, o_mem_req}, 32'h0);
      if (!nt.err) check("op_data", o_op_data & nt.m, nt.d & nt.m);
    end else if (o_op_done === 1'b1) begin
      check("op_extra", 32'h1, 32'h0);
    end
  end

  initial begin
    repeat (6000) @(posedge i_ref_clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {i_op_valid, i_index_long, i_wr_en, i_wr_is_addr, i_sw_wr_en, i_sw_wr_byte} = 6'h00;
    {i_ea_mode, i_index_reg_sel, i_rd_sel, i_op_size, i_implied_sel} = 16'h0000;
    {i_wr_size, i_rd_size, i_addr_reg_sel, i_wr_sel} = 10'h000;
    {i_ext_word0, i_ext_word1, i_sw_wr_data, i_wr_data} = 80'h0;
    mm = '{coe_pkg::M_IND, coe_pkg::M_POSTINC, coe_pkg::M_PREDEC, coe_pkg::M_DISP,
      coe_pkg::M_INDEX, coe_pkg::M_ABS_S, coe_pkg::M_ABS_L, coe_pkg::M_PC_DISP,
      coe_pkg::M_PC_INDEX};
    seed = 32'hF041_6A6B;
    i_pc = rnd() & 32'hFFFF_FFFE;
    i_quick_data = 8'h80;
    i_arst_n = 1'b0;
    for (int i = 0; i < 8; i++) {dreg[i], areg[i]} = 64'h0;
    repeat (3) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1 check("sw_reset", {16'h0, o_status_word}, 32'h0000_2700);
    for (int i = 0; i < 8; i++) begin
      wr(1'b0, i[2:0], coe_pkg::SZ_LONG, rnd() & 32'hFFFF_FFFE);
      wr(1'b1, i[2:0], coe_pkg::SZ_LONG, rnd() & 32'hFFFF_FFFE);
    end
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], coe_pkg::SZ_LONG, i[3] ? areg[i[2:0]] : dreg[i[2:0]]);
    end
    wr(1'b0, 3'h3, coe_pkg::SZ_BYTE, 32'hFFFF_FF12);
    rd(4'h3, coe_pkg::SZ_LONG, dreg[3]);
    wr(1'b0, 3'h3, coe_pkg::SZ_WORD, 32'hAAAA_8E34);
    rd(4'h3, coe_pkg::SZ_LONG, dreg[3]);
    rd(4'h3, coe_pkg::SZ_BYTE, dreg[3] & 32'h0000_00FF);
    rd(4'h3, coe_pkg::SZ_WORD, dreg[3] & 32'h0000_FFFF);
    wr(1'b1, 3'h2, coe_pkg::SZ_WORD, 32'h0000_8002);
    rd(4'hA, coe_pkg::SZ_LONG, 32'hFFFF_8002);
    rd(4'hA, coe_pkg::SZ_WORD, 32'h0000_8002);
    r0 = n_ref;
    wr(1'b1, 3'h2, coe_pkg::SZ_BYTE, 32'h0000_0055);
    repeat (2) @(posedge i_ref_clk);
    check("wr_refused", 32'(n_ref - r0), 32'h1);
    rd(4'hA, coe_pkg::SZ_LONG, 32'hFFFF_8002);
    op(coe_pkg::M_DREG, coe_pkg::SZ_BYTE, 3'h3, 4'h0, 1'b0, 16'h0, 16'h0, dreg[3], 32'h0, 1'b0);
    op(coe_pkg::M_AREG, coe_pkg::SZ_LONG, 3'h2, 4'h0, 1'b0, 16'h0, 16'h0, areg[2], 32'h0, 1'b0);
    op(coe_pkg::M_QUICK, coe_pkg::SZ_LONG, 3'h0, 4'h0, 1'b0, 16'h0, 16'h0, 32'hFFFF_FF80, 32'h0,
       1'b0);
    op(coe_pkg::M_IMM, coe_pkg::SZ_WORD, 3'h0, 4'h0, 1'b0, 16'h1234, 16'h0, 32'h1234, 32'h0, 1'b0);
    op(coe_pkg::M_IMM, coe_pkg::SZ_LONG, 3'h0, 4'h0, 1'b0, 16'hCAFE, 16'h0BEE, 32'hCAFE_0BEE,
       32'h0, 1'b0);
    for (int j = 0; j < 4; j++) begin
      i_implied_sel <= j[1:0];
      d = j == 0 ? 32'h0000_2700 : j == 1 ? 32'h0 : j == 2 ? areg[7] : i_pc;
      op(coe_pkg::M_IMPLIED, j == 0 ? coe_pkg::SZ_WORD : coe_pkg::SZ_LONG, 3'h0, 4'h0, 1'b0,
         16'h0, 16'h0, d, 32'h0, 1'b0);
    end
    for (int k = 0; k < 27; k++) begin
      md = mm[k / 3];
      sz = 2'(k % 3);
      b = 3'(k + 4);
      t = rnd();
      e0 = t[31:16] & (md == coe_pkg::M_ABS_S ? 16'h7FFE : 16'hFFFE);
      base = areg[b];
      step = sz == coe_pkg::SZ_BYTE ? (b == 3'h7 ? 32'h2 : 32'h1) : sz == coe_pkg::SZ_WORD ? 32'h2
        : 32'h4;
      xv = t[3] ? areg[t[2:0]] : dreg[t[2:0]];
      if (!t[4]) xv = sx16(xv[15:0]);
      case (md)
        coe_pkg::M_IND, coe_pkg::M_POSTINC: ea = base;
        coe_pkg::M_PREDEC: ea = base - step;
        coe_pkg::M_DISP: ea = base + sx16(e0);
        coe_pkg::M_INDEX: ea = base + xv + {{24{e0[7]}}, e0[7:0]};
        coe_pkg::M_ABS_S: ea = {16'h0, e0};
        coe_pkg::M_ABS_L: ea = {e0, t[15:1], 1'b0};
        coe_pkg::M_PC_DISP: ea = i_pc + sx16(e0);
        default: ea = i_pc + xv + {{24{e0[7]}}, e0[7:0]};
      endcase
      d = {mb(ea), mb(ea + 1), mb(ea + 2), mb(ea + 3)};
      if (sz == coe_pkg::SZ_WORD) d = {16'h0, mb(ea), mb(ea + 1)};
      if (sz == coe_pkg::SZ_BYTE) d = {24'h0, mb(ea)};
      op(md, sz, b, t[3:0], t[4], e0, {t[15:1], 1'b0}, d, ea, 1'b0);
      if (md == coe_pkg::M_POSTINC) areg[b] = base + step;
      if (md == coe_pkg::M_PREDEC) areg[b] = ea;
      rd({1'b1, b}, coe_pkg::SZ_LONG, areg[b]);
      if (areg[b][0]) wr(1'b1, b, coe_pkg::SZ_LONG, areg[b] & 32'hFFFF_FFFE);
    end
    wr(1'b1, 3'h1, coe_pkg::SZ_LONG, 32'h0000_1001);
    op(coe_pkg::M_POSTINC, coe_pkg::SZ_WORD, 3'h1, 4'h0, 1'b0, 16'h0, 16'h0, 32'h0, 32'h1001, 1'b1);
    op(coe_pkg::M_IND, coe_pkg::SZ_LONG, 3'h1, 4'h0, 1'b0, 16'h0, 16'h0, 32'h0, 32'h1001, 1'b1);
    rd(4'h9, coe_pkg::SZ_LONG, 32'h0000_1001);
    op(coe_pkg::M_IND, coe_pkg::SZ_BYTE, 3'h1, 4'h0, 1'b0, 16'h0, 16'h0, {24'h0, mb(32'h1001)},
       32'h1001, 1'b0);
    supervisor_stack_ptr = areg[7];
    sw(1'b0, 16'hFFFF, 16'hA71F);
    sw(1'b1, 16'h0000, 16'hA700);
    sw(1'b0, 16'h0300, 16'h0300);
    rd(4'hF, coe_pkg::SZ_LONG, 32'h0);
    wr(1'b1, 3'h7, coe_pkg::SZ_LONG, 32'h0000_4440);
    rd(4'hF, coe_pkg::SZ_LONG, 32'h0000_4440);
    i_implied_sel <= coe_pkg::IMP_SSP;
    op(coe_pkg::M_IMPLIED, coe_pkg::SZ_LONG, 3'h0, 4'h0, 1'b0, 16'h0, 16'h0, supervisor_stack_ptr, 32'h0, 1'b0);
    sw(1'b0, 16'h2700, 16'h0300);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1 check("sw_rereset", {16'h0, o_status_word}, 32'h0000_2700);
    rd(4'hF, coe_pkg::SZ_LONG, 32'h0);
    tally_and_finish();
  end
endmodule
